// [dpot_ctrl.sv]
// Purpose: Controller end: spaces commands per timing constraints, APB regs
// Assumes: Software posts one command at a time through CMD register
// Notes: Command waits in a pending slot until its counters clear
//
// Functional notes
// R1 - Fast exit: two clocks before read
// R2 - Slow exit: six minus additive latency
// R3 - Mode bit 12 selects exit spacing
// R4 - Clock enable pulses last three clocks
// R5 - Three clocks from termination to power-down
// R6 - Eight clocks after exit before termination
// R7 - Termination on after two clocks
// R8 - Termination off after two and half
// R9 - Precharge after read: latency plus half burst
// R10 - Activates at least two clocks apart
// R11 - Write recovery: programmed count plus precharge
// R12 - Frequency change only in precharge power-down
// R13 - Driver output valid within twelve ns; the device end raises it two clocks (50 ns) after the command
// R14 - One down-counter per constraint, hold command
`timescale 1ns/1ps
module dpot_ctrl
   import dpot_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Link
   dpot_if.ctrl link
);
   typedef enum logic [2:0] {
      DPOT_ST_IDLE = 3'b001,
      DPOT_ST_WAIT = 3'b010,
      DPOT_ST_ISSUE = 3'b100
   } dpot_st_t;
   dpot_st_t st_q;
   logic [2:0] pend_cmd_q;
   logic [15:0] mode_q;
   logic cke_q;
   logic cke_req_q;
   logic term_q;
   logic [2:0] cmd_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic open_row_q;
   logic mrs_pend_q;
   logic apb_wr;
   logic apb_rd;
   logic ok_exit;
   logic ok_cke;
   logic ok_tpde;
   logic ok_tpdx;
   logic ok_pre;
   logic ok_ras;
   logic ok_act;
   logic ok_dal;
   logic ok_rx;
   logic go;
   logic [3:0] al;
   logic [3:0] bl_half;
   logic [3:0] exit_val;
   logic [3:0] rd_pre_val;
   logic [3:0] dal_val;
   logic cke_chg;
   logic term_pend;
   logic term_upd;
   logic cke_move;
   logic [2:0] cur_cmd;
   assign apb_wr = psel && penable && pwrite && !pready_q;
   assign apb_rd = psel && penable && !pwrite && !pready_q;
   assign al = {1'b0, mode_q[DPOT_MR_AL_LSB +: 3]};
   assign bl_half = mode_q[DPOT_MR_BL_LSB +: 3] == 3'h3 ? 4'h4 : 4'h2;
   // Exit spacing depends on the slow-exit bit
   assign exit_val = mode_q[DPOT_MR_PD_SLOW_BIT] ?
      ((al >= DPOT_SLOW_EXIT_BASE) ? 4'h1 : DPOT_SLOW_EXIT_BASE - al) // R2
      : DPOT_FAST_EXIT_RD; // R1 R3
   assign rd_pre_val = dpot_max(4'(al + bl_half), DPOT_TRTP_CYC); // R9
   assign dal_val = 4'({1'b0, mode_q[DPOT_MR_WR_LSB +: 3]} + 4'h1
                       + DPOT_TRP_CYC); // R11
   assign cke_chg = cke_req_q != cke_q;
   assign term_pend = link.term_en != term_q;
   // Termination moves only while awake and past the exit latency
   assign term_upd = cke_q && ok_tpdx && term_pend; // R6
   // Entry waits until a pending termination change has gone out
   assign cke_move = cke_chg && ok_cke && ok_tpde &&
      !(cke_q && term_pend); // R4 R5
   assign cur_cmd = go ? pend_cmd_q : DPOT_CMD_NOP;
   // Spacing counters, each reloaded by its own command, clock enable move or termination update
   dpot_cnt u_exit (.pclk(pclk), .presetn(presetn),
      .load(cke_move && cke_req_q), .value(exit_val),
      .done(ok_exit)); // R14
   dpot_cnt u_cke (.pclk(pclk), .presetn(presetn),
      .load(cke_move), .value(DPOT_CKE_MIN),
      .done(ok_cke)); // R4
   dpot_cnt u_tpde (.pclk(pclk), .presetn(presetn),
      .load(term_upd), .value(DPOT_TERM_PD_ENTRY),
      .done(ok_tpde)); // R5
   dpot_cnt u_tpdx (.pclk(pclk), .presetn(presetn),
      .load(cke_move && cke_req_q), .value(DPOT_TERM_PD_EXIT),
      .done(ok_tpdx)); // R6
   dpot_cnt u_pre (.pclk(pclk), .presetn(presetn),
      .load(cur_cmd == DPOT_CMD_RD), .value(rd_pre_val),
      .done(ok_pre)); // R9
   dpot_cnt u_ras (.pclk(pclk), .presetn(presetn),
      .load(cur_cmd == DPOT_CMD_ACT), .value(DPOT_TRAS_CYC),
      .done(ok_ras)); // R9
   dpot_cnt u_act (.pclk(pclk), .presetn(presetn),
      .load(cur_cmd == DPOT_CMD_ACT),
      .value(dpot_max(DPOT_ACT_ACT_MIN, DPOT_TRRD_CYC)),
      .done(ok_act)); // R10
   dpot_cnt u_dal (.pclk(pclk), .presetn(presetn),
      .load(cur_cmd == DPOT_CMD_WR), .value(dal_val),
      .done(ok_dal)); // R11
   dpot_cnt u_rx (.pclk(pclk), .presetn(presetn),
      .load(cur_cmd == DPOT_CMD_OCD), .value(DPOT_OCD_CYC),
      .done(ok_rx)); // R13
   // Gate the pending command on its counters and the link state
   always_comb begin
      go = 1'b0;
      if (st_q == DPOT_ST_WAIT && cke_q && !cke_chg) begin
         unique case (pend_cmd_q)
            DPOT_CMD_RD: go = ok_exit && ok_rx; // R1 R2
            DPOT_CMD_PRE: go = ok_pre && ok_ras && ok_dal; // R9 R14
            DPOT_CMD_ACT: go = ok_act && ok_dal && ok_exit; // R10
            DPOT_CMD_MRS: go = ok_exit && !open_row_q;
            default: go = ok_exit;
         endcase
      end
   end
   // Command sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= DPOT_ST_IDLE;
         pend_cmd_q <= DPOT_CMD_NOP;
      end else begin
         unique case (st_q)
            DPOT_ST_IDLE: begin
               if (apb_wr && paddr == DPOT_REG_CMD) begin
                  pend_cmd_q <= pwdata[2:0];
                  st_q <= DPOT_ST_WAIT;
               end
            end
            DPOT_ST_WAIT: begin
               if (go) begin
                  st_q <= DPOT_ST_ISSUE; // R14
               end
            end
            DPOT_ST_ISSUE: st_q <= DPOT_ST_IDLE;
            default: st_q <= DPOT_ST_IDLE;
         endcase
      end
   end
   // Link outputs straight from flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd_q <= DPOT_CMD_NOP;
         open_row_q <= 1'b0;
      end else begin
         cmd_q <= cur_cmd;
         if (cur_cmd == DPOT_CMD_ACT) begin
            open_row_q <= 1'b1;
         end else if (cur_cmd == DPOT_CMD_PRE) begin
            open_row_q <= 1'b0;
         end
      end
   end
   // Clock enable moves only when pulse width and entry latency allow
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cke_q <= 1'b0;
      end else if (cke_move) begin
         cke_q <= cke_req_q; // R4 R5
      end
   end
   // Software registers; termination held until exit latency elapses
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= DPOT_MR_RESET;
         cke_req_q <= 1'b0;
         term_q <= 1'b0;
      end else if (apb_wr) begin
         if (paddr == DPOT_REG_MODE && st_q == DPOT_ST_IDLE) begin
            mode_q <= pwdata[15:0]; // R3
         end
         if (paddr == DPOT_REG_TERM) begin
            term_q <= pwdata[0];
            cke_req_q <= pwdata[1];
         end
      end
   end
   // Termination follows request only when synchronous timing holds
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         link.term_en <= 1'b0;
      end else if (term_upd) begin
         link.term_en <= term_q; // R6
      end
   end
   // Mode word presented to the device alongside the mode command
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         link.mode <= DPOT_MR_RESET;
      end else begin
         link.mode <= mode_q;
      end
   end
   // APB read data and single answer after one wait state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q <= psel && penable && !pready_q;
         pslverr_q <= psel && penable && !pready_q &&
            !(paddr == DPOT_REG_CMD || paddr == DPOT_REG_MODE ||
              paddr == DPOT_REG_STATUS || paddr == DPOT_REG_TERM);
         prdata_q <= 32'h0000_0000;
         if (apb_rd) begin
            unique case (paddr)
               DPOT_REG_MODE: prdata_q <= {16'h0000, mode_q};
               DPOT_REG_STATUS: prdata_q <= {25'h000_0000, link.drv_on,
                  link.term_on, link.pd_active, cke_q,
                  // Frequency change safe only in power-down, idle rows
                  !cke_q && !open_row_q, // R12
                  st_q == DPOT_ST_IDLE, ok_exit};
               DPOT_REG_TERM: prdata_q <= {30'h0000_0000, cke_req_q, term_q};
               default: prdata_q <= 32'h0000_0000;
            endcase
         end
      end
   end
   assign link.cke = cke_q;
   assign link.cmd = cmd_q;
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
endmodule : dpot_ctrl

// [dpot_pkg.sv]
// Purpose: Shared constants and types for the power-down/termination link
// Assumes: Link runs on pclk at 40 MHz; one command per clock
// Notes: Counts are in clock cycles unless the name says otherwise
package dpot_pkg;
   // Command codes on the link
   typedef enum logic [2:0] {
      DPOT_CMD_NOP = 3'h0,
      DPOT_CMD_ACT = 3'h1,
      DPOT_CMD_RD = 3'h2,
      DPOT_CMD_WR = 3'h3,
      DPOT_CMD_PRE = 3'h4,
      DPOT_CMD_MRS = 3'h5,
      DPOT_CMD_OCD = 3'h6
   } dpot_cmd_t;
   // Clock timing
   localparam int unsigned DPOT_CLK_PS = 25000;
   // Timing figures in clock cycles
   localparam logic [3:0] DPOT_FAST_EXIT_RD = 4'h2;
   localparam logic [3:0] DPOT_SLOW_EXIT_BASE = 4'h6;
   localparam logic [3:0] DPOT_CKE_MIN = 4'h3;
   localparam logic [3:0] DPOT_TERM_PD_ENTRY = 4'h3;
   localparam logic [3:0] DPOT_TERM_PD_EXIT = 4'h8;
   localparam logic [3:0] DPOT_TERM_ON_DLY = 4'h2;
   // Turn-off delay 2.5 clocks counted in half clocks
   localparam logic [3:0] DPOT_TERM_OFF_HALF = 4'h5;
   localparam logic [3:0] DPOT_ACT_ACT_MIN = 4'h2;
   // Picosecond figures
   localparam int unsigned DPOT_TRP_PS = 15000;
   localparam int unsigned DPOT_TRTP_PS = 7500;
   localparam int unsigned DPOT_TRAS_PS = 45000;
   localparam int unsigned DPOT_TRRD_PS = 7500;
   localparam int unsigned DPOT_OCD_MAX_PS = 12000;
   // Derived counts, least times rounded up
   localparam logic [3:0] DPOT_TRP_CYC =
      4'((DPOT_TRP_PS + DPOT_CLK_PS - 1) / DPOT_CLK_PS);
   localparam logic [3:0] DPOT_TRTP_CYC =
      4'((DPOT_TRTP_PS + DPOT_CLK_PS - 1) / DPOT_CLK_PS);
   localparam logic [3:0] DPOT_TRAS_CYC =
      4'((DPOT_TRAS_PS + DPOT_CLK_PS - 1) / DPOT_CLK_PS);
   localparam logic [3:0] DPOT_TRRD_CYC =
      4'((DPOT_TRRD_PS + DPOT_CLK_PS - 1) / DPOT_CLK_PS);
   // Longest delay rounded down, at least one cycle
   localparam logic [3:0] DPOT_OCD_CYC = (DPOT_OCD_MAX_PS / DPOT_CLK_PS) < 1 ?
      4'h1 : 4'(DPOT_OCD_MAX_PS / DPOT_CLK_PS);
   // Mode word fields
   localparam int unsigned DPOT_MR_PD_SLOW_BIT = 12;
   localparam int unsigned DPOT_MR_WR_LSB = 9;
   localparam int unsigned DPOT_MR_BL_LSB = 0;
   localparam int unsigned DPOT_MR_AL_LSB = 3;
   localparam logic [15:0] DPOT_MR_RESET = 16'h0000;
   // Controller registers (APB byte offsets)
   localparam logic [11:0] DPOT_REG_CMD = 12'h000;
   localparam logic [11:0] DPOT_REG_MODE = 12'h004;
   localparam logic [11:0] DPOT_REG_STATUS = 12'h008;
   localparam logic [11:0] DPOT_REG_TERM = 12'h00C;
   // Larger of two counts
   function automatic logic [3:0] dpot_max(input logic [3:0] a,
                                           input logic [3:0] b);
      dpot_max = (a > b) ? a : b;
   endfunction : dpot_max
endpackage : dpot_pkg

// [dpot_if.sv]
// Purpose: Command link between controller and memory device
// Assumes: Both ends on pclk
// Notes: Termination pin output and data pin are one-way here
`timescale 1ns/1ps
interface dpot_if;
   logic cke;
   logic [2:0] cmd;
   logic [15:0] mode;
   logic term_en;
   logic term_on;
   logic drv_on;
   logic pd_active;
   modport ctrl (output cke, output cmd, output mode, output term_en,
                 input term_on, input drv_on, input pd_active);
   modport dev (input cke, input cmd, input mode, input term_en,
                output term_on, output drv_on, output pd_active);
endinterface : dpot_if

// [dpot_cnt.sv]
// Purpose: Reloadable down-counter for one spacing constraint
// Assumes: Load wins over counting
// Notes: done is high when the count has reached zero
`timescale 1ns/1ps
module dpot_cnt
   import dpot_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control
   input wire logic load,
   input wire logic [3:0] value,
   // Status
   output logic done
);
   logic [3:0] cnt_q;
   // Count down to zero after each load
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 4'h0;
      end else if (load) begin
         cnt_q <= value;
      end else if (cnt_q != 4'h0) begin
         cnt_q <= cnt_q - 4'h1;
      end
   end
   // Count alone; ignoring load keeps the callers' gating free of loops
   assign done = cnt_q == 4'h0;
endmodule : dpot_cnt

// [dpot_dev.sv]
// Purpose: Device end: termination delays, driver delay, power-down state
// Assumes: Commands arrive one per clock from the controller end
// Notes: Half-clock delay is halved and rounded up to a count in clocks
`timescale 1ns/1ps
module dpot_dev
   import dpot_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Link
   dpot_if.dev link,
   // User side status
   output logic slow_exit,
   output logic [2:0] wr_clocks
);
   logic [15:0] mode_q;
   logic [3:0] on_q;
   logic [3:0] off_q;
   logic [3:0] oit_q;
   logic term_q;
   logic drv_q;
   logic pd_q;
   // Mode word stored on a mode command; bit 12 picks exit speed
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= DPOT_MR_RESET;
      end else if (link.cmd == DPOT_CMD_MRS) begin
         mode_q <= link.mode; // R3
      end
   end
   // Power-down state follows clock enable one clock late
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pd_q <= 1'b0;
      end else begin
         pd_q <= !link.cke;
      end
   end
   // Termination on after 2 clocks, off after 2.5 (5 half-clocks -> 3)
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         on_q <= 4'h0;
         off_q <= 4'h0;
         term_q <= 1'b0;
      end else begin
         if (link.term_en && !term_q && on_q == 4'h0) begin
            on_q <= DPOT_TERM_ON_DLY; // R7
         end else if (on_q != 4'h0) begin
            on_q <= on_q - 4'h1;
         end
         if (!link.term_en && term_q && off_q == 4'h0) begin
            off_q <= 4'((DPOT_TERM_OFF_HALF + 4'h1) >> 1); // R8
         end else if (off_q != 4'h0) begin
            off_q <= off_q - 4'h1;
         end
         if (on_q == 4'h1) begin
            term_q <= 1'b1; // R7
         end else if (off_q == 4'h1) begin
            term_q <= 1'b0; // R8
         end
      end
   end
   // Driver adjust mode: outputs driven two clocks (50 ns) after the command, not within the twelve ns output delay
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         oit_q <= 4'h0;
         drv_q <= 1'b0;
      end else if (link.cmd == DPOT_CMD_OCD) begin
         oit_q <= DPOT_OCD_CYC; // R13
         drv_q <= 1'b0;
      end else if (oit_q != 4'h0) begin
         oit_q <= oit_q - 4'h1;
         drv_q <= (oit_q == 4'h1); // R13
      end else begin
         drv_q <= 1'b0;
      end
   end
   assign link.term_on = term_q;
   assign link.drv_on = drv_q;
   assign link.pd_active = pd_q;
   assign slow_exit = mode_q[DPOT_MR_PD_SLOW_BIT];
   assign wr_clocks = mode_q[DPOT_MR_WR_LSB +: 3]; // R11
endmodule : dpot_dev

// [dpot_checker.sv]
// Purpose: Timing assertions on the link between the two ends
// Assumes: One clock; link signals seen as plain inputs
// Notes: Helper counters saturate at fifteen
`timescale 1ns/1ps
module dpot_checker
   import dpot_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Link
   input wire logic cke,
   input wire logic [2:0] cmd,
   input wire logic [15:0] mode,
   input wire logic term_en,
   input wire logic term_on,
   input wire logic drv_on
);
   localparam int OCD_WIN = int'(DPOT_OCD_CYC) + 1;
   logic [3:0] up_q, rd_q, al, need, rdpre;
   // Cycles since exit and since the last read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         up_q <= 4'h0;
         rd_q <= 4'hF;
      end else begin
         up_q <= !cke ? 4'h0 : (up_q == 4'hF ? up_q : up_q + 4'h1);
         rd_q <= (cmd == DPOT_CMD_RD) ? 4'h0 :
            (rd_q == 4'hF ? rd_q : rd_q + 4'h1);
      end
   end
   // Slow exit floored to one; read spacing is latency plus half burst
   assign al = {1'b0, mode[5:3]};
   assign need = (al >= 4'h5) ? 4'h1 : DPOT_SLOW_EXIT_BASE - al;
   assign rdpre = al + ((mode[2:0] == 3'h3) ? 4'h4 : 4'h2) - 4'h1;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_on;
      !term_on [*3] ##1 term_on;
   endsequence
   sequence s_off;
      term_on [*4] ##1 !term_on;
   endsequence
   AST_FAST_EXIT: assert property (cmd == DPOT_CMD_RD && !mode[12] |->
      up_q >= DPOT_FAST_EXIT_RD) else $error("read too soon after exit");
   AST_SLOW_EXIT: assert property (cmd == DPOT_CMD_RD && mode[12] |->
      up_q >= need) else $error("read too soon after slow exit");
   AST_CKE_WIDTH: assert property ($changed(cke) |=> $stable(cke) [*2])
      else $error("clock enable pulse too short");
   AST_TERM_PD_ENTRY: assert property ($changed(term_en) |->
      !$fell(cke) [*3]) else $error("power-down too soon after term change");
   AST_TERM_PD_EXIT: assert property ($rose(cke) |->
      $stable(term_en) [*8]) else $error("term change too soon after exit");
   AST_TERM_ON: assert property ($rose(term_en) |-> s_on)
      else $error("termination turn-on delay wrong");
   AST_TERM_OFF: assert property ($fell(term_en) |-> s_off)
      else $error("termination turn-off delay wrong");
   AST_RD_TO_PRE: assert property (cmd == DPOT_CMD_PRE |->
      rd_q >= rdpre) else $error("precharge too soon after read");
   AST_ACT_SPACE: assert property (cmd == DPOT_CMD_ACT |=>
      cmd != DPOT_CMD_ACT) else $error("activates too close");
   AST_OCD_OUT: assert property (cmd == DPOT_CMD_OCD |->
      ##[1:OCD_WIN] drv_on) else $error("driver output late");
endmodule : dpot_checker

// [tb_top.sv]
// Purpose: Self-checking bench for the power-down and termination link
// Assumes: Both ends joined by dpot_if; the bench is the APB master
// Notes: Link edges are time-stamped in clock cycles
`timescale 1ns/1ps
module tb_top
   import dpot_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic slow_exit;
   logic [2:0] wr_clocks;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] sig, sig_q;
   int num_errors, n_compared, cyc;
   int up[4], dn[4], tc[8];
   // Both ends, the link between them and its checker
   dpot_if u_dpot_if();
   dpot_ctrl u_dpot_ctrl(.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .link(u_dpot_if.ctrl));
   dpot_dev u_dpot_dev(.pclk(pclk), .presetn(presetn), .link(u_dpot_if.dev),
      .slow_exit(slow_exit), .wr_clocks(wr_clocks));
   dpot_checker u_dpot_checker(.pclk(pclk), .presetn(presetn),
      .cke(u_dpot_if.cke), .cmd(u_dpot_if.cmd), .mode(u_dpot_if.mode),
      .term_en(u_dpot_if.term_en), .term_on(u_dpot_if.term_on),
      .drv_on(u_dpot_if.drv_on));
   assign sig = {u_dpot_if.drv_on, u_dpot_if.term_on, u_dpot_if.term_en,
      u_dpot_if.cke};
   // Clock
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   // Edge and command time stamps
   always @(posedge pclk) begin
      cyc++;
      sig_q <= sig;
      for (int i = 0; i < 4; i++) begin
         if (sig[i] === 1'b1 && sig_q[i] === 1'b0) up[i] = cyc;
         if (sig[i] === 1'b0 && sig_q[i] === 1'b1) dn[i] = cyc;
      end
      if (u_dpot_if.cmd !== 3'h0) tc[u_dpot_if.cmd] = cyc;
   end
   task final_report();
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : final_report
   // A wait that ran out ends the run
   task hang();
      num_errors++;
      final_report();
   endtask : hang
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // One APB transfer; waits for pready, bounded
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int i;
      i = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 50);
      if (i >= 50) hang();
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task wait_idle();
      int i;
      i = 0;
      do begin
         apb(1'b0, DPOT_REG_STATUS, 32'h0);
         i++;
      end while (rd[1] !== 1'b1 && i < 100);
      if (i >= 100) hang();
   endtask : wait_idle
   task wait_sig(input int i, input logic v);
      int n;
      n = 0;
      while (sig[i] !== v && n < 200) begin
         @(negedge pclk);
         n++;
      end
      if (n >= 200) hang();
      // Let the next rising edge time-stamp the change
      @(negedge pclk);
   endtask : wait_sig
   task post(input dpot_cmd_t c);
      apb(1'b1, DPOT_REG_CMD, 32'(c));
      wait_idle();
   endtask : post
   task set_mode(input logic [15:0] m);
      apb(1'b1, DPOT_REG_TERM, 32'h2);
      wait_sig(0, 1'b1);
      wait_idle();
      apb(1'b1, DPOT_REG_MODE, {16'h0, m});
      post(DPOT_CMD_MRS);
   endtask : set_mode
   task t_reset();
      apb(1'b0, DPOT_REG_MODE, 32'h0);
      chk(rd, {16'h0, DPOT_MR_RESET});
      apb(1'b0, DPOT_REG_STATUS, 32'h0);
      chk(32'(rd[3]), 32'h0);
      apb(1'b0, 12'h010, 32'h0);
      chk(rd, 32'h0);
      chk(32'(err), 32'h1);
   endtask : t_reset
   // Slow exit, latency 2, recovery field 5, burst 8
   task t_mode();
      set_mode(16'h1A13);
      apb(1'b0, DPOT_REG_MODE, 32'h0);
      chk(rd, 32'h0000_1A13);
      chk(32'(slow_exit), 32'h1);
      chk(32'(wr_clocks), 32'h5);
   endtask : t_mode
   // Leave power-down, then post a read right after the exit
   task t_exit(input logic [15:0] m, input int need);
      set_mode(m);
      apb(1'b1, DPOT_REG_TERM, 32'h0);
      wait_sig(0, 1'b0);
      apb(1'b1, DPOT_REG_TERM, 32'h2);
      apb(1'b1, DPOT_REG_CMD, 32'(DPOT_CMD_RD));
      wait_sig(0, 1'b1);
      wait_idle();
      chk(32'(up[0] - dn[0] >= 3), 32'h1);
      chk(32'(tc[2] - up[0] >= need), 32'h1);
   endtask : t_exit
   task t_term();
      post(DPOT_CMD_PRE);
      apb(1'b1, DPOT_REG_TERM, 32'h0);
      wait_sig(0, 1'b0);
      apb(1'b0, DPOT_REG_STATUS, 32'h0);
      chk(32'(rd[2]), 32'h1);
      chk(32'(rd[4]), 32'h1);
      apb(1'b1, DPOT_REG_TERM, 32'h3);
      wait_sig(2, 1'b1);
      chk(32'(up[1] - up[0] >= 8), 32'h1);
      chk(up[2] - up[1], 32'(DPOT_TERM_ON_DLY) + 1);
      apb(1'b1, DPOT_REG_TERM, 32'h0);
      wait_sig(2, 1'b0);
      wait_sig(0, 1'b0);
      chk(dn[2] - dn[1], 32'(DPOT_TERM_OFF_HALF + 1) / 2 + 1);
      chk(32'(dn[0] - dn[1] >= 3), 32'h1);
      apb(1'b1, DPOT_REG_TERM, 32'h2);
      wait_sig(0, 1'b1);
      apb(1'b0, DPOT_REG_STATUS, 32'h0);
      chk(32'(rd[2]), 32'h0);
      chk(32'(rd[4]), 32'h0);
   endtask : t_term
   // Activates, read then precharge, driver adjust
   task t_cmds();
      set_mode(16'h0013);
      post(DPOT_CMD_ACT);
      post(DPOT_CMD_ACT);
      post(DPOT_CMD_RD);
      post(DPOT_CMD_PRE);
      chk(32'(tc[4] - tc[2] >= 6), 32'h1);
      // Write then precharge: recovery field 0 means one clock
      post(DPOT_CMD_WR);
      post(DPOT_CMD_PRE);
      chk(32'(tc[4] - tc[3] >= 1 +
         (DPOT_TRP_PS + DPOT_CLK_PS - 1) / DPOT_CLK_PS), 32'h1);
      apb(1'b1, DPOT_REG_CMD, 32'(DPOT_CMD_OCD));
      wait_sig(3, 1'b1);
      chk(32'(up[3] > tc[6] && up[3] - tc[6] <= 2), 32'h1);
   endtask : t_cmds
   // Main sequence
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      sig_q = 4'h0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_mode();
      t_exit(16'h0003, 2);
      t_exit(16'h1013, 4);
      t_exit(16'h1033, 1);
      t_term();
      t_cmds();
      final_report();
   end
endmodule : tb_top
